// file: rtl/gpcd_pkg.sv
package gpcd_pkg;

    // ==========================================================
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] GPCD_IDX_PIN61 = 8'h48;
    localparam logic [7:0] GPCD_IDX_RSV49 = 8'h49;
    localparam logic [7:0] GPCD_IDX_RSV4A = 8'h4A;
    localparam logic [7:0] GPCD_IDX_PORT1 = 8'h4B;
    localparam logic [7:0] GPCD_IDX_PORT2 = 8'h4C;
    localparam logic [7:0] GPCD_IDX_PORT3 = 8'h4D;
    localparam logic [7:0] GPCD_IDX_PORT4 = 8'h4E;
    localparam logic [7:0] GPCD_IDX_IRQ_STAT = 8'h60;
    localparam logic [7:0] GPCD_IDX_IRQ_MASK = 8'h61;
    localparam logic [7:0] GPCD_IDX_CTRL = 8'h62;

    // ==========================================================
    // Field positions of the pin configuration register.
    localparam int GPCD_CFG_DIR = 0;
    localparam int GPCD_CFG_POL = 1;
    localparam int GPCD_CFG_FN_LO = 2;
    localparam int GPCD_CFG_OD = 7;
    localparam logic [7:0] GPCD_CFG_WMASK = 8'h8F;
    localparam logic [7:0] GPCD_CFG_RESET = 8'h01;

    // ==========================================================
    // Function selects.
    localparam logic [1:0] GPCD_FN_GPIO = 2'h0;
    localparam logic [1:0] GPCD_FN_LED = 2'h1;
    localparam logic [1:0] GPCD_FN_IRQ = 2'h2;

    // ==========================================================
    // Data register masks, reset values and interrupt bits.
    localparam logic [7:0] GPCD_DATA_RESET = 8'h00;
    localparam logic [7:0] GPCD_P1_MASK = 8'hFF;
    localparam logic [7:0] GPCD_P2_MASK = 8'hF7;
    localparam logic [7:0] GPCD_P3_MASK = 8'hFF;
    localparam logic [7:0] GPCD_P4_MASK = 8'h0F;
    localparam logic [7:0] GPCD_P3_MAIN_MASK = 8'h0C;
    localparam int GPCD_IRQ_EDGE = 0;
    localparam int GPCD_CTRL_LED = 0;

    typedef enum logic [1:0] {
        GPCD_IDLE = 2'b00,
        GPCD_ACCESS = 2'b01
    } gpcd_state_e;

endpackage

// file: rtl/gpcd_sync.sv
module gpcd_sync
    import gpcd_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Refuses a width that the flip-flops cannot hold.
    if (WIDTH < 1) begin : g_width_check
        $error("gpcd_sync width must be positive.");
    end

    // ==========================================================
    // Two flip-flop synchroniser.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

// file: rtl/gpcd_pin.sv
module gpcd_pin
    import gpcd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] cfg,
    input wire logic data_bit,
    input wire logic led_level,
    input wire logic pin_sync,
    output logic pin_out,
    output logic pin_oe,
    output logic level,
    output logic edge_pulse
);

    logic prev_q;
    logic out_level;
    logic is_output;
    logic [1:0] fn_sel;

    assign fn_sel = cfg[GPCD_CFG_FN_LO +: 2];
    // Input when the direction bit is one, unless the LED function is selected. [R1]
    assign is_output = ~cfg[GPCD_CFG_DIR] || (fn_sel == GPCD_FN_LED);
    // Output level with polarity applied, LED select overrides data. [R2] [R3]
    assign out_level = ((fn_sel == GPCD_FN_LED) ? led_level : data_bit) ^ cfg[GPCD_CFG_POL];
    // Open drain drives only a low level. [R4]
    assign pin_out = cfg[GPCD_CFG_OD] ? 1'b0 : out_level;
    assign pin_oe = is_output && (cfg[GPCD_CFG_OD] ? ~out_level : 1'b1);
    // Read value is the pin after polarity. [R11]
    assign level = pin_sync ^ cfg[GPCD_CFG_POL];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= pin_sync;
        end
    end

    // Either edge while the interrupt function is selected. [R12]
    assign edge_pulse = (fn_sel == GPCD_FN_IRQ) && (prev_q != pin_sync);

endmodule

// file: rtl/gpcd_top.sv
// Behaviour
// R1: Config bit 0: one input, zero output.
// R2: Config bit 1 inverts pin polarity.
// R3: Bits 3:2 pick GPIO, LED, edge interrupt.
// R4: Bit 7 open drain; bits 6:4 reserved.
// R5: Offsets 49 and 4A read zero.
// R6: Port 1 data at 4B, reset zero.
// R7: Port 2 data at 4C, bit 3 reserved.
// R8: Port 3 data at 4D, reset zero.
// R9: Port 3 bits 2,3 also main reset.
// R10: Port 4 data at 4E, low nibble only.
// R11: Reads give pin after polarity; writes drive. Port reads OR in the latch, and pin 61 as GPIO drives only its polarity bit.
// R12: Either pin edge raises interrupt event.
module gpcd_top
    import gpcd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic main_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] port1_in,
    output logic [7:0] port1_out,
    input wire logic [7:0] port2_in,
    output logic [7:0] port2_out,
    input wire logic [7:0] port3_in,
    output logic [7:0] port3_out,
    input wire logic [7:0] port4_in,
    output logic [7:0] port4_out,
    input wire logic pin61_in,
    output logic pin61_out,
    output logic pin61_oe,
    output logic irq
);

    // ==========================================================
    // Registers.
    logic [7:0] cfg_q;
    logic [7:0] p1_q;
    logic [7:0] p2_q;
    logic [7:0] p3_q;
    logic [7:0] p4_q;
    logic [7:0] irq_stat_q;
    logic [7:0] irq_mask_q;
    logic [7:0] ctrl_q;
    logic [31:0] prdata_q;
    logic main_rst_meta_q;
    logic main_rst_q;

    // ==========================================================
    // Synchronised inputs and pin logic.
    logic [31:0] ports_sync;
    logic pin_sync;
    logic pin_level;
    logic edge_pulse;

    gpcd_sync #(.WIDTH(33)) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({pin61_in, port4_in, port3_in, port2_in, port1_in}),
        .sync_out({pin_sync, ports_sync})
    );

    gpcd_pin u_pin (
        .clk(clk),
        .reset(reset),
        .cfg(cfg_q),
        .data_bit(1'b0),
        .led_level(ctrl_q[GPCD_CTRL_LED]),
        .pin_sync(pin_sync),
        .pin_out(pin61_out),
        .pin_oe(pin61_oe),
        .level(pin_level),
        .edge_pulse(edge_pulse)
    );

    // ==========================================================
    // Bus decode.
    function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
        hit = (addr == {2'b00, idx, 2'b00});
    endfunction

    logic wr_en;
    logic rd_en;
    logic sel_cfg;
    logic sel_rsv;
    logic sel_p1;
    logic sel_p2;
    logic sel_p3;
    logic sel_p4;
    logic sel_stat;
    logic sel_mask;
    logic sel_ctrl;
    logic mapped;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && ~pwrite;
    assign wbyte = pwdata[7:0];
    assign sel_cfg = hit(paddr, GPCD_IDX_PIN61);
    assign sel_rsv = hit(paddr, GPCD_IDX_RSV49) || hit(paddr, GPCD_IDX_RSV4A);
    assign sel_p1 = hit(paddr, GPCD_IDX_PORT1);
    assign sel_p2 = hit(paddr, GPCD_IDX_PORT2);
    assign sel_p3 = hit(paddr, GPCD_IDX_PORT3);
    assign sel_p4 = hit(paddr, GPCD_IDX_PORT4);
    assign sel_stat = hit(paddr, GPCD_IDX_IRQ_STAT);
    assign sel_mask = hit(paddr, GPCD_IDX_IRQ_MASK);
    assign sel_ctrl = hit(paddr, GPCD_IDX_CTRL);
    assign mapped = sel_cfg | sel_rsv | sel_p1 | sel_p2 | sel_p3 | sel_p4 | sel_stat | sel_mask | sel_ctrl;
    assign pslverr = psel && penable && ~mapped;

    // Port reads show the input pins ORed with the latch, under the port mask. [R11]
    function automatic logic [7:0] port_rd(input logic [7:0] lat, input logic [7:0] pins, input logic [7:0] m);
        port_rd = (lat | pins) & m;
    endfunction

    assign rd_byte = sel_cfg ? cfg_q :
                     sel_rsv ? 8'h00 : // [R5]
                     sel_p1 ? port_rd(p1_q, ports_sync[7:0], GPCD_P1_MASK) :
                     sel_p2 ? port_rd(p2_q, ports_sync[15:8], GPCD_P2_MASK) :
                     sel_p3 ? port_rd(p3_q, ports_sync[23:16], GPCD_P3_MASK) :
                     sel_p4 ? port_rd(p4_q, ports_sync[31:24], GPCD_P4_MASK) :
                     sel_stat ? irq_stat_q :
                     sel_mask ? irq_mask_q :
                     sel_ctrl ? {ctrl_q[7:1], pin_level} : 8'h00;

    // ==========================================================
    // Main supply reset is synchronised before use.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            main_rst_meta_q <= 1'b0;
            main_rst_q <= 1'b0;
        end else begin
            main_rst_meta_q <= main_reset;
            main_rst_q <= main_rst_meta_q;
        end
    end

    // ==========================================================
    // Configuration and data registers.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_q <= GPCD_CFG_RESET;
            p1_q <= GPCD_DATA_RESET; // [R6]
            p2_q <= GPCD_DATA_RESET; // [R7]
            p3_q <= GPCD_DATA_RESET; // [R8]
            p4_q <= GPCD_DATA_RESET; // [R10]
            ctrl_q <= 8'h00;
            irq_mask_q <= 8'h00;
        end else begin
            if (wr_en && sel_cfg) begin
                cfg_q <= wbyte & GPCD_CFG_WMASK; // [R1] [R2] [R3] [R4]
            end
            if (wr_en && sel_p1) begin
                p1_q <= wbyte & GPCD_P1_MASK; // [R6]
            end
            if (wr_en && sel_p2) begin
                p2_q <= wbyte & GPCD_P2_MASK; // [R7]
            end
            if (main_rst_q) begin
                p3_q <= p3_q & ~GPCD_P3_MAIN_MASK; // [R9]
            end else if (wr_en && sel_p3) begin
                p3_q <= wbyte & GPCD_P3_MASK; // [R8]
            end
            if (wr_en && sel_p4) begin
                p4_q <= wbyte & GPCD_P4_MASK; // [R10]
            end
            if (wr_en && sel_ctrl) begin
                ctrl_q <= {7'h00, wbyte[GPCD_CTRL_LED]};
            end
            if (wr_en && sel_mask) begin
                irq_mask_q <= {7'h00, wbyte[GPCD_IRQ_EDGE]};
            end
        end
    end

    // ==========================================================
    // Sticky status, set wins over write-one-to-clear.
    logic [7:0] stat_set;
    logic [7:0] stat_clr;
    assign stat_set = {7'h00, edge_pulse}; // [R12]
    assign stat_clr = (wr_en && sel_stat) ? wbyte : 8'h00;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_stat_q <= 8'h00;
        end else begin
            irq_stat_q <= (irq_stat_q & ~stat_clr) | stat_set;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ==========================================================
    // Read data register.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && ~penable && ~pwrite) begin
            prdata_q <= {24'h000000, rd_byte};
        end
    end

    assign prdata = prdata_q;

    // ==========================================================
    // Port outputs: written levels.
    assign port1_out = p1_q;
    assign port2_out = p2_q;
    assign port3_out = p3_q;
    assign port4_out = p4_q;

    // ==========================================================
    // Sequences shared by the checks.
    sequence s_rd_setup;
        psel && ~penable && ~pwrite;
    endsequence

    sequence s_rd_access;
        rd_en && pready;
    endsequence

    sequence s_irq_edge;
        (cfg_q[GPCD_CFG_FN_LO +: 2] == GPCD_FN_IRQ) && (pin_sync != $past(pin_sync));
    endsequence

    sequence s_stat_clear;
        wr_en && sel_stat && wbyte[GPCD_IRQ_EDGE] && ~edge_pulse;
    endsequence

    // ==========================================================
    // Checks.
    chk_rsv_zero: assert property (@(posedge clk) disable iff (reset) // [R5]
        (psel && ~penable && ~pwrite && sel_rsv) |=> (prdata == 32'h0000_0000))
        else $error("Reserved offset read not zero.");
    chk_cfg_write: assert property (@(posedge clk) disable iff (reset) // [R4]
        (wr_en && sel_cfg) |=> (cfg_q == ($past(wbyte) & GPCD_CFG_WMASK)))
        else $error("Config write wrong.");
    chk_p2_bit3: assert property (@(posedge clk) disable iff (reset) // [R7]
        p2_q[3] == 1'b0)
        else $error("Port 2 bit 3 set.");
    chk_p4_high: assert property (@(posedge clk) disable iff (reset) // [R10]
        p4_q[7:4] == 4'h0)
        else $error("Port 4 high nibble set.");
    chk_p3_main: assert property (@(posedge clk) disable iff (reset) // [R9]
        main_rst_q |=> (p3_q[3:2] == 2'b00))
        else $error("Port 3 bits not cleared.");
    chk_p1_write: assert property (@(posedge clk) disable iff (reset) // [R6]
        (wr_en && sel_p1) |=> (p1_q == $past(wbyte)))
        else $error("Port 1 write lost.");
    chk_p3_write: assert property (@(posedge clk) disable iff (reset) // [R8]
        (wr_en && sel_p3 && ~main_rst_q) |=> (p3_q == $past(wbyte)))
        else $error("Port 3 write lost.");
    chk_dir_in: assert property (@(posedge clk) disable iff (reset) // [R1]
        (cfg_q[GPCD_CFG_DIR] && cfg_q[3:2] != GPCD_FN_LED) |-> ~pin61_oe)
        else $error("Input pin driven.");
    chk_edge_irq: assert property (@(posedge clk) disable iff (reset) // [R12]
        edge_pulse |=> irq_stat_q[GPCD_IRQ_EDGE])
        else $error("Edge event lost.");
    chk_pol_read: assert property (@(posedge clk) disable iff (reset) // [R2]
        pin_level == (pin_sync ^ cfg_q[GPCD_CFG_POL]))
        else $error("Polarity wrong.");
    chk_rd_data: assert property (@(posedge clk) disable iff (reset) // [R11]
        (s_rd_setup ##1 s_rd_access) |-> (prdata == {24'h000000, $past(rd_byte)}))
        else $error("Read data not held in access phase.");
    chk_led_drive: assert property (@(posedge clk) disable iff (reset) // [R3]
        (cfg_q[GPCD_CFG_FN_LO +: 2] == GPCD_FN_LED && ~cfg_q[GPCD_CFG_OD]) |->
            (pin61_oe && (pin61_out == (ctrl_q[GPCD_CTRL_LED] ^ cfg_q[GPCD_CFG_POL]))))
        else $error("LED drive wrong.");
    chk_od_low: assert property (@(posedge clk) disable iff (reset) // [R4]
        cfg_q[GPCD_CFG_OD] |-> (pin61_out == 1'b0))
        else $error("Open drain drove high.");
    chk_edge_seen: assert property (@(posedge clk) disable iff (reset) // [R12]
        s_irq_edge |=> irq_stat_q[GPCD_IRQ_EDGE])
        else $error("Pin edge not recorded.");
    chk_stat_clear: assert property (@(posedge clk) disable iff (reset) // [R12]
        s_stat_clear |=> ~irq_stat_q[GPCD_IRQ_EDGE])
        else $error("Status bit not cleared.");
    chk_fn_no_irq: assert property (@(posedge clk) disable iff (reset) // [R3]
        ((cfg_q[GPCD_CFG_FN_LO +: 2] != GPCD_FN_IRQ) && ~irq_stat_q[GPCD_IRQ_EDGE]) |=> ~irq_stat_q[GPCD_IRQ_EDGE])
        else $error("Edge event outside interrupt function.");
    chk_p3_keep: assert property (@(posedge clk) disable iff (reset) // [R9]
        main_rst_q |=> ((p3_q & ~GPCD_P3_MAIN_MASK) == ($past(p3_q) & ~GPCD_P3_MAIN_MASK)))
        else $error("Main reset touched other port 3 bits.");
    chk_main_sync: assert property (@(posedge clk) disable iff (reset) // [R9]
        main_reset [*2] |=> main_rst_q)
        else $error("Main reset not seen.");
    chk_irq_mask: assert property (@(posedge clk) disable iff (reset) // [R12]
        ~irq_mask_q[GPCD_IRQ_EDGE] |-> ~irq)
        else $error("Masked interrupt raised.");
    chk_p4_write: assert property (@(posedge clk) disable iff (reset) // [R10]
        (wr_en && sel_p4) |=> (p4_q == ($past(wbyte) & GPCD_P4_MASK)))
        else $error("Port 4 write wrong.");

endmodule

// file: verification/testbench.sv
module testbench
    import gpcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Clock, reset and design instance.
    logic clk = 0, reset = 1, main_reset = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic [7:0] port1_in = 0, port2_in = 0, port3_in = 0, port4_in = 0;
    logic [7:0] port1_out, port2_out, port3_out, port4_out;
    logic pin61_in = 0, pin61_out, pin61_oe, irq, last_err;
    int bad_count = 0, num_checks = 0;

    always #2 clk = ~clk;

    gpcd_top gpcd_top_i (.clk(clk), .reset(reset), .main_reset(main_reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port1_in(port1_in), .port1_out(port1_out), .port2_in(port2_in),
        .port2_out(port2_out), .port3_in(port3_in), .port3_out(port3_out),
        .port4_in(port4_in), .port4_out(port4_out), .pin61_in(pin61_in),
        .pin61_out(pin61_out), .pin61_oe(pin61_oe), .irq(irq));

    // ==========================================================
    // Bus tasks and comparison.
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] outs(input int i);
        case (i)
            0: return port1_out;
            1: return port2_out;
            2: return port3_out;
            default: return port4_out;
        endcase
    endfunction

    function automatic logic [7:0] mk(input int i);
        case (i)
            0: return 8'hFF;
            1: return 8'hF7;
            2: return 8'hFF;
            default: return 8'h0F;
        endcase
    endfunction

    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) check(0, 1);
        q = prdata;
        last_err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(0, a, 0);
        check(q, {24'h0, e});
    endtask

    task automatic wait_pins();
        repeat (5) @(posedge clk);
    endtask

    // ==========================================================
    // Test sequence.
    initial begin
        repeat (8) @(posedge clk);
        reset <= 0;
        rd(ad(GPCD_IDX_PIN61), 8'h01);
        check(pin61_oe, 0);
        for (int i = 0; i < 4; i++) begin
            rd(ad(GPCD_IDX_PORT1 + 8'(i)), 8'h00);
            wr(ad(GPCD_IDX_PORT1 + 8'(i)), 8'hFF);
            rd(ad(GPCD_IDX_PORT1 + 8'(i)), mk(i));
            check(outs(i), mk(i));
        end
        wr(ad(GPCD_IDX_RSV49), 8'hFF);
        rd(ad(GPCD_IDX_RSV49), 8'h00);
        rd(ad(GPCD_IDX_RSV4A), 8'h00);
        rd(12'h200, 8'h00);
        check(last_err, 1);
        check(pready, 1);
        main_reset <= 1;
        repeat (4) @(posedge clk);
        main_reset <= 0;
        rd(ad(GPCD_IDX_PORT3), 8'hF3);
        rd(ad(GPCD_IDX_PORT1), 8'hFF);
        wr(ad(GPCD_IDX_PORT1), 8'h00);
        port1_in <= 8'h5A;
        port4_in <= 8'hF0;
        wait_pins();
        rd(ad(GPCD_IDX_PORT1), 8'h5A);
        rd(ad(GPCD_IDX_PORT4), 8'h0F);
        wr(ad(GPCD_IDX_PIN61), 8'hFF);
        rd(ad(GPCD_IDX_PIN61), 8'h8F);
        wr(ad(GPCD_IDX_PIN61), 8'h00);
        wait_pins();
        check({pin61_oe, pin61_out}, 2'b10);
        wr(ad(GPCD_IDX_CTRL), 8'h01);
        wr(ad(GPCD_IDX_PIN61), 8'h04);
        wait_pins();
        check({pin61_oe, pin61_out}, 2'b11);
        wr(ad(GPCD_IDX_PIN61), 8'h84);
        wait_pins();
        check(pin61_oe, 0);
        wr(ad(GPCD_IDX_PIN61), 8'h03);
        pin61_in <= 1;
        wait_pins();
        apb(0, ad(GPCD_IDX_CTRL), 0);
        check(q[0], 0);
        wr(ad(GPCD_IDX_PIN61), 8'h01);
        wait_pins();
        apb(0, ad(GPCD_IDX_CTRL), 0);
        check(q[0], 1);
        wr(ad(GPCD_IDX_IRQ_MASK), 8'h01);
        wr(ad(GPCD_IDX_IRQ_STAT), 8'h01);
        pin61_in <= 0;
        wait_pins();
        check(irq, 0);
        wr(ad(GPCD_IDX_PIN61), 8'h09);
        wait_pins();
        pin61_in <= 1;
        wait_pins();
        check(irq, 1);
        rd(ad(GPCD_IDX_IRQ_STAT), 8'h01);
        wr(ad(GPCD_IDX_IRQ_STAT), 8'h01);
        wait_pins();
        check(irq, 0);
        pin61_in <= 0;
        wait_pins();
        check(irq, 1);
        wr(ad(GPCD_IDX_IRQ_MASK), 8'h00);
        wait_pins();
        check(irq, 0);
        end_of_test();
    end

    initial begin
        #20000;
        bad_count++;
        end_of_test();
    end
endmodule
